// ---- logic/imr_host_port.sv ----
// Purpose: Eight-bit host port reaching an internal space indirectly
// Assumes: Host strobes and mode pin pass three-flop synchronisers; internal space answers reads
// Notes:   Registers reach internal space through data windows
`timescale 1ns/100ps
`default_nettype none
module imr_host_port #(
  parameter logic [1:0] BOARD_POS = 2'h0
) (
  // Clock and reset
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_rst_n,
  // Host pins
  input  wire logic                         i_cs_n,
  input  wire logic                         i_rd_n,
  input  wire logic                         i_wr_n,
  input  wire logic                         i_direction_strobe_convention,
  input  wire logic [2:0]                   i_addr,
  input  wire logic [7:0]                   i_data,
  output logic      [7:0]                   o_data,
  output logic                              o_data_oe_n,
  output logic                              o_ready,
  // Sync and timing
  input  wire logic                         i_sync_pin,
  input  wire logic                         i_clk_div_tick,
  input  wire logic [imr_pkg::HOLD_W-1:0]   i_holdoff,
  // Internal space
  output imr_pkg::imr_iacc_s                o_iacc,
  input  wire logic [imr_pkg::WORD_W-1:0]   i_irdata,
  // Channel side
  output logic                              o_chan_a_active,
  output logic                              o_chan_b_active,
  output logic                              o_sync,
  output logic [2:0]                        o_block_sync
);
  // Pin synchronisers, three stages
  logic [2:0] cs_s, rd_s, wr_s, sy_s;
  logic [2:0] mode_s;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cs_s <= 3'h7; rd_s <= 3'h7; wr_s <= 3'h7; sy_s <= 3'h0; mode_s <= 3'h0;
    end else begin
      cs_s <= {cs_s[1:0], i_cs_n};
      rd_s <= {rd_s[1:0], i_rd_n};
      wr_s <= {wr_s[1:0], i_wr_n};
      sy_s <= {sy_s[1:0], i_sync_pin};
      mode_s <= {mode_s[1:0], i_direction_strobe_convention};
    end
  end
  logic cs_r, rd_r, wr_r, sync_r, mode_r;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cs_r <= 1'b1; rd_r <= 1'b1; wr_r <= 1'b1; sync_r <= 1'b0; mode_r <= 1'b0;
    end else begin
      if (cs_s[1] == cs_s[2]) cs_r <= cs_s[2];
      if (rd_s[1] == rd_s[2]) rd_r <= rd_s[2];
      if (wr_s[1] == wr_s[2]) wr_r <= wr_s[2];
      // One-cycle sync pulses must pass
      sync_r <= sy_s[2];
      if (mode_s[1] == mode_s[2]) mode_r <= mode_s[2];
    end
  end

  logic rd_act, wr_act, acc_act, acc_prev_r;
  always_comb begin
    if (mode_r) begin
      rd_act = !cs_r && !rd_r && wr_r;
      wr_act = !cs_r && !rd_r && !wr_r;
    end else begin
      rd_act = !cs_r && !rd_r;
      wr_act = !cs_r && !wr_r;
    end
  end
  assign acc_act = rd_act || wr_act;
  logic acc_start;
  assign acc_start = acc_act && !acc_prev_r;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) acc_prev_r <= 1'b0;
    else acc_prev_r <= acc_act;
  end

  // Registers
  logic [7:0] acc_ctl_r, pointer_r, chan_r, meth_r, soft_r;
  logic [7:0] win_low_r, win_mid_r, win_high_r;
  logic       low_rd_data_r;
  logic       sel_ok;
  logic [1:0] instr_id;
  always_comb begin
    instr_id = acc_ctl_r[imr_pkg::ACC_INSTR_LO +: 2];
    if (!acc_ctl_r[imr_pkg::ACC_INSTR_HI]) sel_ok = 1'b1;
    else if (acc_ctl_r[imr_pkg::ACC_INSTR_HI-1]) sel_ok = (instr_id == BOARD_POS);
    else sel_ok = (instr_id[0] == BOARD_POS[0]);
  end

  logic wr_evt, rd_evt;
  assign wr_evt = acc_start && wr_act;
  assign rd_evt = acc_start && rd_act;
  logic low_wr, low_rd, soft_go;
  // Low window write trigger, unselected ignored
  assign low_wr = wr_evt && (i_addr == imr_pkg::ADR_DATA_LOW) && sel_ok;
  assign low_rd = rd_evt && (i_addr == imr_pkg::ADR_DATA_LOW) && sel_ok;
  assign soft_go = wr_evt && (i_addr == imr_pkg::ADR_SOFT_START)
                   && i_data[imr_pkg::SS_SOFT];

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      acc_ctl_r <= imr_pkg::RST_BYTE;
      chan_r <= imr_pkg::RST_BYTE;
      meth_r <= imr_pkg::RST_BYTE;
      soft_r <= imr_pkg::RST_BYTE;
      win_mid_r <= imr_pkg::RST_BYTE;
      win_high_r <= imr_pkg::RST_BYTE;
    end else if (wr_evt) begin
      case (i_addr)
        imr_pkg::ADR_ACCESS_CTL: acc_ctl_r <= i_data;
        imr_pkg::ADR_CHAN_ENA:   chan_r <= i_data & imr_pkg::MASK_CHAN;
        imr_pkg::ADR_START_METH: meth_r <= i_data & imr_pkg::MASK_METH;
        imr_pkg::ADR_SOFT_START: soft_r <= i_data & imr_pkg::MASK_SOFT;
        imr_pkg::ADR_DATA_MID:   win_mid_r <= i_data;
        imr_pkg::ADR_DATA_HIGH:  win_high_r <= i_data & imr_pkg::MASK_HIGH;
        default: ;
      endcase
    end else if (low_rd_data_r) begin
      win_mid_r <= i_irdata[15:8];
      win_high_r <= {2'b00, i_irdata[imr_pkg::WORD_W-1:16]};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) win_low_r <= imr_pkg::RST_BYTE;
    else if (wr_evt && i_addr == imr_pkg::ADR_DATA_LOW) win_low_r <= i_data;
    else if (low_rd_data_r) win_low_r <= i_irdata[7:0];
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) pointer_r <= imr_pkg::RST_BYTE;
    else if (wr_evt && i_addr == imr_pkg::ADR_POINTER) pointer_r <= i_data;
    else if ((low_wr || low_rd) && acc_ctl_r[imr_pkg::ACC_AUTOINC])
      pointer_r <= pointer_r + 8'h01;
  end

  // Internal access state
  imr_pkg::imr_state_e st_r;
  logic [1:0] lat_r;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_iacc <= '0;
      lat_r <= 2'h0;
      low_rd_data_r <= 1'b0;
      st_r <= imr_pkg::IMR_IDLE;
    end else begin
      o_iacc.wr <= 1'b0;
      o_iacc.rd <= 1'b0;
      low_rd_data_r <= 1'b0;
      case (st_r)
        imr_pkg::IMR_IDLE: begin
          if (acc_start) begin
            st_r <= imr_pkg::IMR_BUSY;
            lat_r <= imr_pkg::IRD_LAT;
            o_iacc.addr <= {acc_ctl_r[1:0], pointer_r};
            o_iacc.wdata <= {win_high_r[5:0], win_mid_r, i_data};
            o_iacc.wr <= low_wr;
            o_iacc.rd <= low_rd;
          end
        end
        imr_pkg::IMR_BUSY: begin
          lat_r <= lat_r - 2'h1;
          if (lat_r == 2'h1) begin
            st_r <= imr_pkg::IMR_DONE;
            low_rd_data_r <= (i_addr == imr_pkg::ADR_DATA_LOW) && rd_act && sel_ok;
          end
        end
        imr_pkg::IMR_DONE: if (!acc_act) st_r <= imr_pkg::IMR_IDLE;
        default: st_r <= imr_pkg::IMR_IDLE;
      endcase
    end
  end

  logic fetch_lag_r, ans_ok;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) fetch_lag_r <= 1'b0;
    else fetch_lag_r <= low_rd_data_r;
  end
  assign ans_ok = (st_r == imr_pkg::IMR_DONE) && !low_rd_data_r && !fetch_lag_r;

  always_comb begin
    if (mode_r) o_ready = !(ans_ok && acc_act);
    else o_ready = !(acc_act && !ans_ok);
  end

  // Read data path, status bits, six-bit readback
  logic [7:0] rd_mux;
  always_comb begin
    case (i_addr)
      imr_pkg::ADR_DATA_LOW:   rd_mux = win_low_r;
      imr_pkg::ADR_DATA_MID:   rd_mux = win_mid_r;
      imr_pkg::ADR_DATA_HIGH:  rd_mux = win_high_r & imr_pkg::MASK_HIGH;
      imr_pkg::ADR_CHAN_ENA:   rd_mux = {4'h0, o_chan_b_active, chan_r[2],
                                         o_chan_a_active, chan_r[0]};
      imr_pkg::ADR_START_METH: rd_mux = meth_r;
      imr_pkg::ADR_SOFT_START: rd_mux = soft_r;
      imr_pkg::ADR_POINTER:    rd_mux = pointer_r;
      imr_pkg::ADR_ACCESS_CTL: rd_mux = acc_ctl_r;
      default:                 rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_data <= 8'h00;
      o_data_oe_n <= 1'b1;
    end else begin
      o_data <= rd_mux;
      o_data_oe_n <= !rd_act;
    end
  end

  logic sync_prev_r, pin_evt;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) sync_prev_r <= 1'b0;
    else sync_prev_r <= sync_r;
  end
  assign pin_evt = meth_r[imr_pkg::SM_EDGE] ? (sync_r && !sync_prev_r) : sync_r;

  logic [imr_pkg::HOLD_W-1:0] hold_r;
  logic hold_run_r, soft_evt;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      hold_r <= '0;
      hold_run_r <= 1'b0;
    end else if (soft_go) begin
      hold_r <= i_holdoff;
      hold_run_r <= 1'b1;
    end else if (hold_run_r && i_clk_div_tick) begin
      if (hold_r <= imr_pkg::HOLD_ONE) hold_run_r <= 1'b0;
      else hold_r <= hold_r - imr_pkg::HOLD_ONE;
    end
  end
  assign soft_evt = hold_run_r && i_clk_div_tick && (hold_r <= imr_pkg::HOLD_ONE);

  // Sync source select, first sync only, enables
  logic sync_evt, any_act;
  assign sync_evt = meth_r[imr_pkg::SM_PIN_SYNC] ? pin_evt : soft_evt;
  assign any_act = o_chan_a_active || o_chan_b_active;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_chan_a_active <= 1'b0;
      o_chan_b_active <= 1'b0;
      o_sync <= 1'b0;
      o_block_sync <= 3'h0;
    end else begin
      o_sync <= sync_evt && !(meth_r[imr_pkg::SM_FIRST] && any_act);
      o_block_sync <= {3{sync_evt && !(meth_r[imr_pkg::SM_FIRST] && any_act)}}
                      & {soft_r[imr_pkg::SS_AGC], soft_r[imr_pkg::SS_DC],
                         soft_r[imr_pkg::SS_PN]};
      if (sync_evt && chan_r[imr_pkg::CH_A_ENA]) o_chan_a_active <= 1'b1;
      if (sync_evt && chan_r[imr_pkg::CH_B_ENA]) o_chan_b_active <= 1'b1;
    end
  end

  // Assertions
  a_autoinc_step: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (low_wr && acc_ctl_r[7] && !(wr_evt && i_addr == 3'h6)) |=> pointer_r == $past(pointer_r) + 8'h01)
    else $error("pointer did not advance");
  a_high_six: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    win_high_r[7:6] == 2'b00) else $error("upper window kept top bits");
  a_ignore_unsel: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (acc_start && !sel_ok) |=> !o_iacc.wr && !o_iacc.rd) else $error("unselected access ran");
  a_low_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    low_wr |=> o_iacc.wr && o_iacc.wdata[7:0] == $past(i_data)) else $error("write not issued");
  a_ready_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (!mode_r && acc_start) |-> !o_ready) else $error("ready not low at start");
  a_ack_done: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (mode_r && acc_act && st_r != imr_pkg::IMR_DONE) |-> o_ready) else $error("early ack");
  a_status_bit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_addr == 3'h3) |-> rd_mux[1] == o_chan_a_active && rd_mux[3] == o_chan_b_active)
    else $error("status bit wrong");
  a_first_only: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (sync_evt && meth_r[5] && any_act) |=> !o_sync) else $error("resync not ignored");
endmodule : imr_host_port
`default_nettype wire

// ---- inc/imr_pkg.sv ----
// Purpose: Constants and carriers for the indirect host port
// Assumes: 8-bit host data, 3-bit register address, 10-bit internal address
// Notes:   Offsets are the external register addresses
package imr_pkg;
  localparam logic [2:0] ADR_DATA_LOW   = 3'h0;
  localparam logic [2:0] ADR_DATA_MID   = 3'h1;
  localparam logic [2:0] ADR_DATA_HIGH  = 3'h2;
  localparam logic [2:0] ADR_CHAN_ENA   = 3'h3;
  localparam logic [2:0] ADR_START_METH = 3'h4;
  localparam logic [2:0] ADR_SOFT_START = 3'h5;
  localparam logic [2:0] ADR_POINTER    = 3'h6;
  localparam logic [2:0] ADR_ACCESS_CTL = 3'h7;
  // Access control fields
  localparam int ACC_AUTOINC = 7;
  localparam int ACC_INSTR_HI = 5;
  localparam int ACC_INSTR_LO = 2;
  // Channel enable/status fields
  localparam int CH_A_ENA = 0;
  localparam int CH_A_STA = 1;
  localparam int CH_B_ENA = 2;
  localparam int CH_B_STA = 3;
  // Start method fields
  localparam int SM_PIN_SYNC = 0;
  localparam int SM_EDGE     = 4;
  localparam int SM_FIRST    = 5;
  // Software start fields
  localparam int SS_SOFT = 0;
  localparam int SS_PN   = 4;
  localparam int SS_DC   = 5;
  localparam int SS_AGC  = 6;
  // Masks and widths
  localparam logic [7:0] MASK_HIGH  = 8'h3F;
  localparam logic [7:0] MASK_CHAN  = 8'h05;
  localparam logic [7:0] MASK_METH  = 8'h31;
  localparam logic [7:0] MASK_SOFT  = 8'h71;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam int WORD_W = 22;
  localparam int IADR_W = 10;
  localparam int HOLD_W = 16;
  localparam logic [HOLD_W-1:0] HOLD_ONE = 16'h0001;
  localparam logic [1:0] IRD_LAT = 2'h2;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [IADR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } imr_iacc_s;

  typedef enum logic [1:0] {
    IMR_IDLE,
    IMR_BUSY,
    IMR_DONE
  } imr_state_e;
endpackage : imr_pkg

// ---- dv/imr_host_model.sv ----
// Purpose: Host processor model for the indirect port
// Assumes: Mode input picks the strobe convention
// Notes:   Released bus shows the inverse of its last value
`timescale 1ns/100ps
`default_nettype none
module imr_host_model (
  // Clock and mode
  input  wire logic       i_clk_sys,
  input  wire logic       i_mode,
  // Host pins
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic [2:0]      o_addr,
  output logic [7:0]      o_data,
  input  wire logic [7:0] i_data,
  input  wire logic       i_ready
);
  logic timeout;
  initial begin
    {o_cs_n, o_rd_n, o_wr_n} = 3'h7;
    o_addr = 3'h0;
    o_data = 8'h00;
    timeout = 1'b0;
  end
  task automatic wait_ready(input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end while (i_ready !== lvl && n < 40);
    if (i_ready !== lvl) timeout = 1'b1;
  endtask : wait_ready
  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_data <= wr ? d : ~o_data;
    o_cs_n <= 1'b0;
    o_wr_n <= ~wr;
    o_rd_n <= i_mode ? 1'b0 : wr;
    if (!i_mode) wait_ready(1'b0);
    wait_ready(!i_mode);
    q = i_data;
    @(posedge i_clk_sys);
    {o_cs_n, o_rd_n, o_wr_n} <= 3'h7;
    o_data <= ~o_data;
    wait_ready(1'b1);
    repeat (4) @(posedge i_clk_sys);
  endtask : access
endmodule : imr_host_model
`default_nettype wire

// ---- dv/indirect_microport_regs_tb.sv ----
// Purpose: Self-checking bench for the indirect host port
// Assumes: Board position code 0, sync pin idle
// Notes:   Host model drives the pins, bench the rest
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module indirect_microport_regs_tb;
  logic               clk, rst_n, mode, tick, cs_n, rd_n, wr_n, ready;
  logic               act_a, act_b, sync, oe_n, sync_pin, oe_seen;
  logic [2:0]         blk, addr, blk_seen;
  logic [7:0]         hdata, ddata;
  logic [15:0]        holdoff;
  logic [21:0]        irdata;
  imr_pkg::imr_iacc_s iacc, last_acc;
  int                 n_errors, tests_run, n_wr, n_sync;

  imr_host_port dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_direction_strobe_convention(mode), .i_addr(addr), .i_data(hdata),
    .o_data(ddata), .o_data_oe_n(oe_n), .o_ready(ready), .i_sync_pin(sync_pin),
    .i_clk_div_tick(tick), .i_holdoff(holdoff), .o_iacc(iacc), .i_irdata(irdata),
    .o_chan_a_active(act_a), .o_chan_b_active(act_b), .o_sync(sync), .o_block_sync(blk));
  // One chip on its own select, so readback is valid
  imr_host_model host_u (.i_clk_sys(clk), .i_mode(mode), .o_cs_n(cs_n), .o_rd_n(rd_n),
    .o_wr_n(wr_n), .o_addr(addr), .o_data(hdata), .i_data(ddata), .i_ready(ready));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) tick <= ~tick;
  // Internal access and sync monitor
  always @(negedge clk) begin
    if (iacc.wr) n_wr++;
    if (iacc.wr || iacc.rd) last_acc = iacc;
    if (sync) blk_seen = blk_seen | blk;
    if (sync) n_sync++;
    if (!oe_n) oe_seen = 1'b1;
  end

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] x;
    oe_seen = 1'b0;
    host_u.access(1'b1, a, d, x);
    `CHK(oe_seen, 1'b0)
  endtask : wreg
  task automatic chk_reg(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] q;
    oe_seen = 1'b0;
    host_u.access(1'b0, a, 8'h00, q);
    `CHK(q, e)
    `CHK(oe_seen, 1'b1)
  endtask : chk_reg
  task automatic t_masks();
    logic [18:0] t [8] = '{{3'h3, 8'hFF, 8'h05}, {3'h4, 8'hFF, 8'h31}, {3'h4, 8'h00, 8'h00},
      {3'h5, 8'h70, 8'h70}, {3'h2, 8'hFF, 8'h3F}, {3'h1, 8'hA5, 8'hA5},
      {3'h6, 8'h5A, 8'h5A}, {3'h7, 8'h80, 8'h80}};
    for (int a = 3; a < 8; a++) chk_reg(3'(a), 8'h00);
    for (int i = 0; i < 8; i++) begin
      wreg(t[i][18:16], t[i][15:8]);
      chk_reg(t[i][18:16], t[i][7:0]);
    end
  endtask : t_masks
  task automatic t_int_write();
    int n;
    wreg(3'h6, 8'h10);
    wreg(3'h2, 8'hEA);
    wreg(3'h1, 8'h5C);
    n = n_wr;
    wreg(3'h0, 8'h3E);
    `CHK(n_wr, n + 1)
    `CHK(last_acc.addr, 10'h010)
    `CHK(last_acc.wdata, {6'h2A, 8'h5C, 8'h3E})
    chk_reg(3'h6, 8'h11);
  endtask : t_int_write
  task automatic t_int_read();
    mode <= 1'b1;
    irdata <= 22'h2B_CDEF;
    repeat (4) @(posedge clk);
    chk_reg(3'h0, 8'hEF);
    `CHK(last_acc.rd, 1'b1)
    `CHK(last_acc.addr, 10'h011)
    chk_reg(3'h1, 8'hCD);
    chk_reg(3'h2, 8'h2B);
    wreg(3'h6, 8'h40);
    chk_reg(3'h6, 8'h40);
    mode <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : t_int_read
  task automatic t_select();
    int n;
    logic [8:0] t [5] = '{{8'hB4, 1'b0}, {8'hA0, 1'b1}, {8'hA4, 1'b0}, {8'hB0, 1'b1},
      {8'h9C, 1'b1}};
    for (int i = 0; i < 5; i++) begin
      // Bit 6 and bits 1:0 kept zero
      wreg(3'h7, t[i][8:1]);
      n = n_wr;
      wreg(3'h0, 8'h01);
      `CHK(n_wr, n + int'(t[i][0]))
    end
  endtask : t_select
  task automatic t_soft();
    holdoff <= 16'h0003;
    blk_seen = 3'h0;
    wreg(3'h5, 8'h71);
    for (int i = 0; i < 200 && !(act_a && act_b); i++) @(posedge clk);
    #1;
    `CHK({act_a, act_b}, 2'b11)
    `CHK(blk_seen, 3'b111)
    chk_reg(3'h3, 8'h0F);
  endtask : t_soft
  task automatic t_pin();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk_reg(3'h3, 8'h00);
    blk_seen = 3'h0;
    n_sync = 0;
    wreg(3'h3, 8'h01);
    wreg(3'h4, 8'h21);
    repeat (8) @(posedge clk);
    `CHK(act_a, 1'b0)
    for (int i = 0; i < 2; i++) begin
      sync_pin <= 1'b1;
      @(posedge clk);
      sync_pin <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK(n_sync, 1)
    end
    wreg(3'h4, 8'h11);
    sync_pin <= 1'b1;
    repeat (8) @(posedge clk);
    sync_pin <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK(n_sync, 2)
    `CHK({act_a, act_b}, 2'b10)
    `CHK(blk_seen, 3'b000)
  endtask : t_pin
  task automatic tally_and_finish();
    $display("Checks run %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    rst_n = 1'b0;
    mode = 1'b0;
    tick = 1'b0;
    holdoff = 16'h0000;
    irdata = 22'h00_0000;
    sync_pin = 1'b0;
    oe_seen = 1'b0;
    n_sync = 0;
    blk_seen = 3'h0;
    n_errors = 0;
    tests_run = 0;
    n_wr = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_masks();
    t_int_write();
    t_int_read();
    t_select();
    t_soft();
    t_pin();
    `CHK(host_u.timeout, 1'b0)
    tally_and_finish();
  end
  initial begin
    #(50 * 30000);
    n_errors++;
    tally_and_finish();
  end
endmodule : indirect_microport_regs_tb
`default_nettype wire
